// [rtl/psc_pkg.sv]
package psc_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int WAKE_FULL_NS = 1_200_000;
  localparam int WAKE_LOWV_NS = 200_000;
  localparam int WAKE_FULL_CYC = (WAKE_FULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_LOWV_CYC = (WAKE_LOWV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_W = 18;
  localparam logic [DLY_W-1:0] ACT_SWITCH_CYC = 18'h00001;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_WAKE_EN = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_CAUSE = 8'h10;
  localparam logic [7:0] OFS_BKP = 8'h20;
  localparam int BKP_WORDS = 8;
  localparam int CFG_SC_BIT = 0;
  localparam int CFG_RET_MAIN_BIT = 1;
  localparam int CFG_RET_PERI_BIT = 2;
  localparam logic [2:0] CFG_RST = 3'h6;
  // ctrl commands
  localparam logic [2:0] CMD_FULL = 3'h1;
  localparam logic [2:0] CMD_REDUCED = 3'h2;
  localparam logic [2:0] CMD_LOWV = 3'h3;
  localparam logic [2:0] CMD_PERIPH = 3'h4;
  localparam logic [2:0] CMD_SLEEP = 3'h5;
  localparam logic [2:0] CMD_SHUT = 3'h6;
  // ----------------------------------------
  // wakeup sources, one bit each
  // ----------------------------------------
  localparam int WK_N = 22;
  localparam logic [WK_N-1:0] WK_STBY_LV = 22'h277FF3;
  localparam logic [WK_N-1:0] WK_SLEEP_HI = 22'h0007E3;
  localparam logic [WK_N-1:0] WK_SLEEP_LV = 22'h0007C3;
  localparam logic [WK_N-1:0] WK_SHUT = 22'h0007C3;
  localparam logic [WK_N-1:0] WK_PERIPH = 22'h020010;
  // ----------------------------------------
  // supply and limits
  // ----------------------------------------
  localparam logic [1:0] SUP_MAIN = 2'h0;
  localparam logic [1:0] SUP_SC = 2'h1;
  localparam logic [1:0] SUP_LDO = 2'h2;
  localparam logic [1:0] SUP_OFF = 2'h3;
  localparam logic [10:0] MV_HI = 11'h47E;
  localparam logic [10:0] MV_LO = 11'h41A;
  localparam logic [10:0] MV_LDO = 11'h2EE;
  localparam logic [7:0] MHZ_FULL = 8'hB4;
  localparam logic [7:0] MHZ_REDUCED = 8'h5A;
  localparam logic [7:0] MHZ_SC = 8'h20;
  localparam logic [7:0] MHZ_LDO = 8'h14;
  // gpio groups {main, low_power, battery}; periph {hp, lp, aon, analog}
  localparam logic [2:0] GPIO_ALL = 3'h7;
  localparam logic [2:0] GPIO_LOW = 3'h3;
  localparam logic [2:0] GPIO_BAT = 3'h1;
  localparam logic [3:0] PER_ALL = 4'hF;
  localparam logic [3:0] PER_LOW = 4'h7;
  localparam logic [3:0] PER_AON = 4'h3;

  typedef enum logic [3:0] {
    ST_FULL, ST_REDUCED, ST_LOWV, ST_PERIPH, ST_STBY, ST_SLEEP, ST_SHUT, ST_SETTLE
  } psc_state_t;

  typedef struct packed {
    logic [1:0] supply_sel;
    logic [10:0] supply_mv;
    logic [7:0] freq_mhz;
    logic pll_en;
    logic clk_gate;
    logic pwr_gate;
    logic [2:0] gpio_grp;
    logic [3:0] periph_grp;
    logic sram_main_on;
    logic sram_peri_on;
  } psc_pwr_t;
endpackage

// [rtl/psc_sync.sv]
`timescale 1ns/1ns
module psc_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } psc_sync_t;
  psc_sync_t r_reg;
  psc_sync_t r_next;

  // first stage feeds only the second
  always_comb begin
    r_next.s1 = nrst_in ? d_in : '0;
    r_next.s2 = nrst_in ? r_reg.s1 : '0;
  end

  always_ff @(posedge clk_in) begin
    r_reg <= r_next;
  end

  assign q_out = r_reg.s2;
endmodule

// [rtl/psc_delay.sv]
`timescale 1ns/1ns
module psc_delay #(
  parameter int W = 18
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic start_in,
  input wire logic [W-1:0] load_in,
  output logic done_out
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
  } psc_dly_t;
  psc_dly_t r_reg;
  psc_dly_t r_next;

  always_comb begin
    r_next = r_reg;
    if (start_in) begin
      r_next.cnt = load_in;
      r_next.done = 1'b0;
    end else if (r_reg.cnt != '0) begin
      r_next.cnt = r_reg.cnt - W'(1);
    end else begin
      r_next.done = 1'b1;
    end
    if (!nrst_in) begin
      r_next = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    r_reg <= r_next;
  end

  assign done_out = r_reg.done;
endmodule

// [rtl/psc_ctrl.sv]
`timescale 1ns/1ns
// How it works
// [R01] full power: main regulator high level, pll allowed
// [R02] full power: 180 MHz limit, all peripherals, gpio groups, whole sram
// [R03] reduced voltage: main regulator low level, 90 MHz cap, full function
// [R04] low voltage: 20 MHz on linear regulator, 32 MHz on switched-cap
// [R05] software picks low-voltage supplies before requesting low-voltage state
// [R06] low voltage and peripheral-only: low-power plus battery gpios only
// [R07] wake to full power takes about 1.2 ms
// [R08] wake to low voltage takes about 200 us
// [R09] peripheral-only entered from low voltage on command; processor power-gated
// [R10] peripheral-only: collector or converter irq wakes; done triggers sleep
// [R11] peripheral-only keeps low-voltage supplies; software configures beforehand
// [R12] wait-for-interrupt in active states enters standby, clock gated only
// [R13] standby from full or reduced: any processor interrupt wakes
// [R14] standby from low voltage: fixed subset of sources wakes
// [R15] sleep entered by software from its active state; aon resources only
// [R16] wireless irq wakes sleep only if entered from full or reduced
// [R17] sleep and shutdown wake sources fixed; none wake peripheral-only
// [R18] return from sleep resets peripheral configuration
// [R19] shutdown from main active states; processor gated; sram lost
// [R20] backup array kept always; sram retainable in sleep and peripheral-only
// [R21] reset lands in full power
// [R22] active to standby or sleep only on software request
// [R23] wake only on enabled source; return to entry state
// [R24] ignore disabled sources; resume after supply and clock stable
// [R25] current state readable by software
module psc_ctrl #(
  parameter int WAKE_FULL_CYCLES = psc_pkg::WAKE_FULL_CYC,
  parameter int WAKE_LOWV_CYCLES = psc_pkg::WAKE_LOWV_CYC
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic wfi_in,
  input wire logic irq_pending_in,
  input wire logic periph_done_in,
  input wire logic [psc_pkg::WK_N-1:0] wake_src_in,
  input wire logic supply_ok_in,
  input wire logic clk_ok_in,
  output psc_pkg::psc_pwr_t pwr_out,
  output logic periph_cfg_rst_out,
  output logic [3:0] state_out
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    psc_pkg::psc_state_t st;
    psc_pkg::psc_state_t ret;
    logic [2:0] cfg;
    logic [psc_pkg::WK_N-1:0] wake_en;
    logic [psc_pkg::WK_N-1:0] cause;
    logic from_sleep;
    logic cfg_rst;
    logic [31:0] rdata;
    logic [psc_pkg::BKP_WORDS-1:0][31:0] bkp;
    psc_pkg::psc_pwr_t pwr;
  } psc_ctrl_t;
  psc_ctrl_t r_reg;
  psc_ctrl_t r_next;

  logic [psc_pkg::WK_N-1:0] wake_sync;
  logic [1:0] ok_sync;
  logic dly_start;
  logic [psc_pkg::DLY_W-1:0] dly_load;
  logic dly_done;

  // asynchronous sources and regulator/pll status cross in here
  psc_sync #(.W(psc_pkg::WK_N)) u_wake_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .d_in(wake_src_in),
    .q_out(wake_sync)
  );

  psc_sync #(.W(2)) u_ok_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .d_in({supply_ok_in, clk_ok_in}),
    .q_out(ok_sync)
  );

  psc_delay #(.W(psc_pkg::DLY_W)) u_delay (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .start_in(dly_start),
    .load_in(dly_load),
    .done_out(dly_done)
  );

  // ----------------------------------------
  // power view of a state
  // ----------------------------------------
  function automatic psc_pkg::psc_pwr_t pwr_of(psc_pkg::psc_state_t s,
      psc_pkg::psc_state_t ret, logic [2:0] cfg);
    psc_pkg::psc_pwr_t p;
    psc_pkg::psc_state_t act;
    logic sc;
    sc = cfg[psc_pkg::CFG_SC_BIT];
    act = (s == psc_pkg::ST_STBY || s == psc_pkg::ST_SETTLE) ? ret : s;
    p.clk_gate = (s == psc_pkg::ST_STBY || s == psc_pkg::ST_SETTLE); // [R12]
    p.pwr_gate = 1'b0;
    p.pll_en = 1'b0;
    p.sram_main_on = 1'b1;
    p.sram_peri_on = 1'b1;
    case (act)
      psc_pkg::ST_FULL: begin
        p.supply_sel = psc_pkg::SUP_MAIN; // [R01]
        p.supply_mv = psc_pkg::MV_HI;
        p.pll_en = 1'b1;
        p.freq_mhz = psc_pkg::MHZ_FULL; // [R02]
        p.gpio_grp = psc_pkg::GPIO_ALL;
        p.periph_grp = psc_pkg::PER_ALL;
      end
      psc_pkg::ST_REDUCED: begin
        p.supply_sel = psc_pkg::SUP_MAIN; // [R03]
        p.supply_mv = psc_pkg::MV_LO;
        p.freq_mhz = psc_pkg::MHZ_REDUCED;
        p.gpio_grp = psc_pkg::GPIO_ALL;
        p.periph_grp = psc_pkg::PER_ALL;
      end
      psc_pkg::ST_LOWV, psc_pkg::ST_PERIPH: begin
        // supply chosen by software ahead of the request [R05] [R11]
        p.supply_sel = sc ? psc_pkg::SUP_SC : psc_pkg::SUP_LDO;
        p.supply_mv = sc ? psc_pkg::MV_LO : psc_pkg::MV_LDO;
        p.freq_mhz = sc ? psc_pkg::MHZ_SC : psc_pkg::MHZ_LDO; // [R04]
        p.gpio_grp = psc_pkg::GPIO_LOW; // [R06]
        p.periph_grp = psc_pkg::PER_LOW;
        if (act == psc_pkg::ST_PERIPH) begin
          p.pwr_gate = 1'b1; // [R09]
          p.clk_gate = 1'b1;
          p.freq_mhz = 8'h00;
          p.sram_main_on = cfg[psc_pkg::CFG_RET_MAIN_BIT]; // [R20]
        end
      end
      default: begin
        // sleep and shutdown: only battery gpios, aon and analog stay [R15]
        p.supply_sel = psc_pkg::SUP_OFF;
        p.supply_mv = 11'h000;
        p.freq_mhz = 8'h00;
        p.clk_gate = 1'b1;
        p.pwr_gate = 1'b1; // [R19]
        p.gpio_grp = psc_pkg::GPIO_BAT;
        p.periph_grp = psc_pkg::PER_AON;
        p.sram_main_on = (s == psc_pkg::ST_SLEEP) && cfg[psc_pkg::CFG_RET_MAIN_BIT]; // [R20]
        p.sram_peri_on = (s == psc_pkg::ST_SLEEP) && cfg[psc_pkg::CFG_RET_PERI_BIT];
      end
    endcase
    return p;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic is_active;
  logic cmd_wr;
  logic [2:0] cmd;
  logic [psc_pkg::WK_N-1:0] allowed;
  logic [psc_pkg::WK_N-1:0] hits;
  logic woke;

  always_comb begin
    r_next = r_reg;
    r_next.cfg_rst = 1'b0;
    dly_start = 1'b0;
    dly_load = psc_pkg::ACT_SWITCH_CYC;
    cmd_wr = wr_in && (addr_in == psc_pkg::OFS_CTRL);
    cmd = wdata_in[2:0];
    is_active = (r_reg.st == psc_pkg::ST_FULL) || (r_reg.st == psc_pkg::ST_REDUCED) ||
                (r_reg.st == psc_pkg::ST_LOWV);
    // permitted sources per low-power state [R14] [R16] [R17] [R10]
    case (r_reg.st)
      psc_pkg::ST_STBY: allowed = (r_reg.ret == psc_pkg::ST_LOWV) ? psc_pkg::WK_STBY_LV : '1;
      psc_pkg::ST_SLEEP:
        allowed = (r_reg.ret == psc_pkg::ST_LOWV) ? psc_pkg::WK_SLEEP_LV : psc_pkg::WK_SLEEP_HI;
      psc_pkg::ST_SHUT: allowed = psc_pkg::WK_SHUT;
      psc_pkg::ST_PERIPH: allowed = psc_pkg::WK_PERIPH;
      default: allowed = '0;
    endcase
    hits = wake_sync & r_reg.wake_en & allowed; // [R23] [R24]
    woke = (hits != '0) ||
           (r_reg.st == psc_pkg::ST_STBY && r_reg.ret != psc_pkg::ST_LOWV &&
            irq_pending_in); // [R13]

    // register writes
    if (wr_in) begin
      case (addr_in)
        psc_pkg::OFS_CFG: r_next.cfg = wdata_in[2:0];
        psc_pkg::OFS_WAKE_EN: r_next.wake_en = wdata_in[psc_pkg::WK_N-1:0];
        psc_pkg::OFS_CAUSE: r_next.cause = r_reg.cause & ~wdata_in[psc_pkg::WK_N-1:0];
        default: begin
        end
      endcase
      for (int i = 0; i < psc_pkg::BKP_WORDS; i++) begin
        if (addr_in == psc_pkg::OFS_BKP + 8'(4 * i)) begin
          r_next.bkp[i] = wdata_in; // [R20]
        end
      end
    end

    case (r_reg.st)
      psc_pkg::ST_FULL, psc_pkg::ST_REDUCED, psc_pkg::ST_LOWV: begin
        if (cmd_wr && cmd == psc_pkg::CMD_SLEEP) begin
          r_next.st = psc_pkg::ST_SLEEP; // [R15] [R22]
          r_next.ret = r_reg.st;
        end else if (cmd_wr && cmd == psc_pkg::CMD_SHUT) begin
          r_next.st = psc_pkg::ST_SHUT; // [R19]
          r_next.ret = r_reg.st;
        end else if (cmd_wr && cmd == psc_pkg::CMD_PERIPH && r_reg.st == psc_pkg::ST_LOWV) begin
          r_next.st = psc_pkg::ST_PERIPH; // [R09]
          r_next.ret = psc_pkg::ST_LOWV;
        end else if (cmd_wr && (cmd == psc_pkg::CMD_FULL || cmd == psc_pkg::CMD_REDUCED ||
                                cmd == psc_pkg::CMD_LOWV)) begin
          r_next.st = psc_pkg::ST_SETTLE; // [R24]
          r_next.ret = (cmd == psc_pkg::CMD_FULL) ? psc_pkg::ST_FULL :
                       (cmd == psc_pkg::CMD_REDUCED) ? psc_pkg::ST_REDUCED : psc_pkg::ST_LOWV;
          dly_start = 1'b1;
        end else if (wfi_in) begin
          r_next.st = psc_pkg::ST_STBY; // [R12] [R22]
          r_next.ret = r_reg.st;
        end
      end
      psc_pkg::ST_PERIPH: begin
        if (woke) begin
          r_next.st = psc_pkg::ST_SETTLE; // [R10]
          dly_start = 1'b1;
          dly_load = psc_pkg::DLY_W'(WAKE_LOWV_CYCLES);
        end else if (periph_done_in) begin
          r_next.st = psc_pkg::ST_SLEEP; // [R10]
        end
      end
      psc_pkg::ST_STBY, psc_pkg::ST_SLEEP, psc_pkg::ST_SHUT: begin
        if (woke) begin
          r_next.st = psc_pkg::ST_SETTLE; // [R23]
          r_next.from_sleep = (r_reg.st != psc_pkg::ST_STBY);
          dly_start = 1'b1;
          dly_load = (r_reg.ret == psc_pkg::ST_LOWV) ? psc_pkg::DLY_W'(WAKE_LOWV_CYCLES) :
                     psc_pkg::DLY_W'(WAKE_FULL_CYCLES); // [R07] [R08]
        end
      end
      psc_pkg::ST_SETTLE: begin
        if (dly_done && ok_sync == 2'h3) begin
          r_next.st = r_reg.ret; // [R24]
          r_next.cfg_rst = r_reg.from_sleep; // [R18]
          r_next.from_sleep = 1'b0;
        end
      end
      default: r_next.st = psc_pkg::ST_FULL;
    endcase
    if (woke && r_reg.st != psc_pkg::ST_SETTLE) begin
      r_next.cause = r_next.cause | hits; // set wins over clear
    end

    // read port, data one cycle later
    r_next.rdata = 32'h0000_0000;
    if (rd_in) begin
      case (addr_in)
        psc_pkg::OFS_CFG: r_next.rdata = {29'h0, r_reg.cfg};
        psc_pkg::OFS_WAKE_EN: r_next.rdata = 32'(r_reg.wake_en);
        psc_pkg::OFS_STATUS: r_next.rdata = {24'h0, r_reg.ret, r_reg.st}; // [R25]
        psc_pkg::OFS_CAUSE: r_next.rdata = 32'(r_reg.cause);
        default: begin
        end
      endcase
      for (int i = 0; i < psc_pkg::BKP_WORDS; i++) begin
        if (addr_in == psc_pkg::OFS_BKP + 8'(4 * i)) begin
          r_next.rdata = r_reg.bkp[i];
        end
      end
    end

    r_next.pwr = pwr_of(r_next.st, r_next.ret, r_next.cfg);
    if (!nrst_in) begin
      r_next = '0;
      r_next.st = psc_pkg::ST_FULL; // [R21]
      r_next.ret = psc_pkg::ST_FULL;
      r_next.cfg = psc_pkg::CFG_RST;
      r_next.pwr = pwr_of(psc_pkg::ST_FULL, psc_pkg::ST_FULL, psc_pkg::CFG_RST);
      dly_start = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    r_reg <= r_next;
  end

  assign rdata_out = r_reg.rdata;
  assign pwr_out = r_reg.pwr;
  assign periph_cfg_rst_out = r_reg.cfg_rst;
  assign state_out = r_reg.st;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_wake_full;
    r_reg.st != psc_pkg::ST_SETTLE ##1 r_reg.st == psc_pkg::ST_SETTLE &&
      r_reg.ret == psc_pkg::ST_FULL && r_reg.from_sleep;
  endsequence

  AST_RESET_FULL: assert property (@(posedge clk_in) disable iff (1'b0) // [R21]
    !nrst_in |=> r_reg.st == psc_pkg::ST_FULL && pwr_out.freq_mhz == psc_pkg::MHZ_FULL)
    else $error("reset did not land in full power");
  AST_FULL_SUPPLY: assert property (r_reg.st == psc_pkg::ST_FULL |-> // [R01]
    pwr_out.supply_mv == psc_pkg::MV_HI && pwr_out.pll_en && pwr_out.gpio_grp == 3'h7)
    else $error("full power supply or pll wrong");
  AST_REDUCED_CAP: assert property (r_reg.st == psc_pkg::ST_REDUCED |-> // [R03]
    pwr_out.freq_mhz == psc_pkg::MHZ_REDUCED && pwr_out.supply_mv == psc_pkg::MV_LO)
    else $error("reduced voltage limit wrong");
  AST_LOWV_FREQ: assert property (r_reg.st == psc_pkg::ST_LOWV |-> // [R04]
    pwr_out.freq_mhz == (r_reg.cfg[0] ? psc_pkg::MHZ_SC : psc_pkg::MHZ_LDO))
    else $error("low voltage frequency limit wrong");
  AST_PERIPH_ENTRY: assert property ($rose(r_reg.st == psc_pkg::ST_PERIPH) |-> // [R09]
    $past(r_reg.st) == psc_pkg::ST_LOWV && pwr_out.pwr_gate && pwr_out.gpio_grp == 3'h3)
    else $error("peripheral-only entry wrong");
  AST_NO_AUTO_SLEEP: assert property (is_active && !wfi_in && !cmd_wr |=> // [R22]
    r_reg.st != psc_pkg::ST_STBY && r_reg.st != psc_pkg::ST_SLEEP)
    else $error("low-power entry without request");
  AST_SHUT_SRAM: assert property (r_reg.st == psc_pkg::ST_SHUT |-> // [R19]
    !pwr_out.sram_main_on && !pwr_out.sram_peri_on && pwr_out.pwr_gate)
    else $error("shutdown kept sram or processor power");
  AST_WAKE_FULL_LONG: assert property (s_wake_full |-> // [R07]
    (r_reg.st == psc_pkg::ST_SETTLE)[*8])
    else $error("wake to full power too fast");
  AST_SLEEP_CFG_RST: assert property ($past(r_reg.st) == psc_pkg::ST_SETTLE && // [R18]
    $past(r_reg.from_sleep) && r_reg.st != psc_pkg::ST_SETTLE |-> periph_cfg_rst_out)
    else $error("no peripheral config reset after sleep");
  AST_NO_WAKE_DISABLED: assert property (r_reg.st == psc_pkg::ST_SHUT && // [R24]
    (wake_sync & r_reg.wake_en & psc_pkg::WK_SHUT) == '0 |=> r_reg.st == psc_pkg::ST_SHUT)
    else $error("shutdown left without enabled source");
endmodule

// [verification/psc_supply_model.sv]
`timescale 1ns/1ns
module psc_supply_model (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [3:0] state_in,
  input wire logic [7:0] lag_in,
  output logic supply_ok_out,
  output logic clk_ok_out
);
  // ----------------------------------------
  // regulator and clock settle
  // ----------------------------------------
  logic [7:0] cnt_reg;
  // with lag_in nonzero, ok stays low outside a settle and until lag_in cycles into it, so a slow supply really holds the resume back
  always_ff @(posedge clk_in) begin
    if (!nrst_in || state_in != psc_pkg::ST_SETTLE) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg != 8'hFF) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
  assign supply_ok_out = (cnt_reg >= lag_in);
  assign clk_ok_out = (cnt_reg >= lag_in);
endmodule

// [verification/psc_ctrl_tb.sv]
`timescale 1ns/1ns
module psc_ctrl_tb;
  localparam int WF = 20;
  localparam int WL = 10;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic wait_for_interrupt_instruction = 1'b0;
  logic irq = 1'b0;
  logic done = 1'b0;
  logic [21:0] wk = 22'h0;
  logic [7:0] lag = 8'h00;
  logic sup_ok;
  logic clk_ok;
  logic cfg_rst;
  logic [31:0] rdata;
  logic [3:0] st;
  psc_pkg::psc_pwr_t pwr;
  int err_total = 0;
  int samples_checked = 0;
  int pulses = 0;
  int p;
  int n;
  logic [31:0] d;

  psc_ctrl #(.WAKE_FULL_CYCLES(WF), .WAKE_LOWV_CYCLES(WL)) dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .wfi_in(wait_for_interrupt_instruction), .irq_pending_in(irq),
    .periph_done_in(done), .wake_src_in(wk), .supply_ok_in(sup_ok), .clk_ok_in(clk_ok),
    .pwr_out(pwr), .periph_cfg_rst_out(cfg_rst), .state_out(st));
  psc_supply_model model (.clk_in(clk_in), .nrst_in(nrst_in), .state_in(st),
    .lag_in(lag), .supply_ok_out(sup_ok), .clk_ok_out(clk_ok));

  initial forever #4 clk_in = ~clk_in;
  // counted mid-cycle so a check one edge after the return edge already sees the pulse
  always @(negedge clk_in) if (cfg_rst === 1'b1) pulses++;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task wait_st(input logic [3:0] s, input int lim);
    n = 0;
    while (st !== s && n < lim) begin
      @(posedge clk_in);
      #1 n++;
    end
  endtask
  task cmd(input logic [2:0] c, input logic [3:0] s);
    wr_reg(psc_pkg::OFS_CTRL, {29'h0, c});
    wait_st(s, 80);
    chk(st, s);
  endtask
  task wake(input logic [21:0] b, input logic i, input logic [3:0] s, input int lo);
    @(posedge clk_in);
    wk <= b;
    irq <= i;
    wait_st(s, 200);
    @(posedge clk_in);
    wk <= 22'h0;
    irq <= 1'b0;
    chk(st, s);
    chk(32'(n >= lo), 32'h1);
  endtask
  task hold(input logic [21:0] b, input logic [3:0] s);
    @(posedge clk_in);
    wk <= b;
    repeat (20) @(posedge clk_in);
    chk(st, s);
  endtask
  task wfi_go();
    @(posedge clk_in);
    wait_for_interrupt_instruction <= 1'b1;
    @(posedge clk_in);
    wait_for_interrupt_instruction <= 1'b0;
    wait_st(psc_pkg::ST_STBY, 10);
    chk(st, psc_pkg::ST_STBY);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset();
    chk(st, psc_pkg::ST_FULL);
    chk(pwr.supply_mv, psc_pkg::MV_HI);
    chk(pwr.pll_en, 1'b1);
    chk(pwr.freq_mhz, psc_pkg::MHZ_FULL);
    chk({pwr.gpio_grp, pwr.periph_grp}, {psc_pkg::GPIO_ALL, psc_pkg::PER_ALL});
    rd_reg(psc_pkg::OFS_CFG);
    chk(d, {29'h0, psc_pkg::CFG_RST});
    rd_reg(8'h80);
    chk(d, 32'h0);
    repeat (30) @(posedge clk_in);
    chk(st, psc_pkg::ST_FULL);
    $display("test reset finished");
  endtask
  task t_active();
    cmd(psc_pkg::CMD_REDUCED, psc_pkg::ST_REDUCED);
    chk(pwr.supply_mv, psc_pkg::MV_LO);
    chk(pwr.freq_mhz, psc_pkg::MHZ_REDUCED);
    chk(pwr.periph_grp, psc_pkg::PER_ALL);
    wr_reg(psc_pkg::OFS_CFG, 32'h7);
    cmd(psc_pkg::CMD_LOWV, psc_pkg::ST_LOWV);
    chk(pwr.supply_sel, psc_pkg::SUP_SC);
    chk(pwr.freq_mhz, psc_pkg::MHZ_SC);
    chk(pwr.gpio_grp, psc_pkg::GPIO_LOW);
    wr_reg(psc_pkg::OFS_CFG, 32'h6);
    lag <= 8'h28;
    cmd(psc_pkg::CMD_REDUCED, psc_pkg::ST_REDUCED);
    chk(32'(n >= 40), 32'h1);
    lag <= 8'h00;
    cmd(psc_pkg::CMD_LOWV, psc_pkg::ST_LOWV);
    chk(pwr.supply_sel, psc_pkg::SUP_LDO);
    chk(pwr.freq_mhz, psc_pkg::MHZ_LDO);
    $display("test active finished");
  endtask
  task t_periph();
    wr_reg(psc_pkg::OFS_WAKE_EN, 32'h020021);
    cmd(psc_pkg::CMD_PERIPH, psc_pkg::ST_PERIPH);
    chk(pwr.pwr_gate, 1'b1);
    chk(pwr.supply_mv, psc_pkg::MV_LDO);
    chk(pwr.gpio_grp, psc_pkg::GPIO_LOW);
    chk(pwr.sram_main_on, 1'b1);
    hold(22'h000010, psc_pkg::ST_PERIPH);
    hold(22'h000001, psc_pkg::ST_PERIPH);
    wake(22'h020000, 1'b0, psc_pkg::ST_LOWV, WL);
    cmd(psc_pkg::CMD_PERIPH, psc_pkg::ST_PERIPH);
    @(posedge clk_in);
    done <= 1'b1;
    @(posedge clk_in);
    done <= 1'b0;
    wait_st(psc_pkg::ST_SLEEP, 10);
    chk(st, psc_pkg::ST_SLEEP);
    chk({pwr.gpio_grp, pwr.periph_grp}, {psc_pkg::GPIO_BAT, psc_pkg::PER_AON});
    hold(22'h000020, psc_pkg::ST_SLEEP);
    p = pulses;
    wake(22'h000001, 1'b0, psc_pkg::ST_LOWV, WL);
    chk(pulses - p, 1);
    $display("test peripheral-only finished");
  endtask
  task t_standby();
    wr_reg(psc_pkg::OFS_WAKE_EN, 32'h010004);
    wfi_go();
    chk({pwr.clk_gate, pwr.pwr_gate}, 2'b10);
    hold(22'h000004, psc_pkg::ST_STBY);
    wake(22'h010000, 1'b0, psc_pkg::ST_LOWV, WL);
    cmd(psc_pkg::CMD_FULL, psc_pkg::ST_FULL);
    wfi_go();
    wake(22'h0, 1'b1, psc_pkg::ST_FULL, WF);
    $display("test standby finished");
  endtask
  task t_sleep();
    wr_reg(psc_pkg::OFS_WAKE_EN, 32'h000021);
    wr_reg(psc_pkg::OFS_BKP + 8'h04, 32'hA5A50001);
    wr_reg(psc_pkg::OFS_CTRL, {29'h0, psc_pkg::CMD_PERIPH});
    repeat (10) @(posedge clk_in);
    chk(st, psc_pkg::ST_FULL);
    cmd(psc_pkg::CMD_SLEEP, psc_pkg::ST_SLEEP);
    rd_reg(psc_pkg::OFS_STATUS);
    chk(d[7:0], 8'h05);
    p = pulses;
    wake(22'h000020, 1'b0, psc_pkg::ST_FULL, WF);
    chk(pulses - p, 1);
    cmd(psc_pkg::CMD_REDUCED, psc_pkg::ST_REDUCED);
    cmd(psc_pkg::CMD_SHUT, psc_pkg::ST_SHUT);
    chk({pwr.pwr_gate, pwr.sram_main_on, pwr.sram_peri_on}, 3'h4);
    rd_reg(psc_pkg::OFS_STATUS);
    chk(d[7:0], 8'h16);
    wake(22'h000001, 1'b0, psc_pkg::ST_REDUCED, WF);
    rd_reg(psc_pkg::OFS_BKP + 8'h04);
    chk(d, 32'hA5A50001);
    rd_reg(psc_pkg::OFS_WAKE_EN);
    chk(d, 32'h00000021);
    // hits so far: collector-free converter, battery, uart, wireless
    rd_reg(psc_pkg::OFS_CAUSE);
    chk(d, 32'h00030021);
    wr_reg(psc_pkg::OFS_CAUSE, 32'h00030021);
    rd_reg(psc_pkg::OFS_CAUSE);
    chk(d, 32'h0);
    $display("test sleep and shutdown finished");
  endtask

  task results();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    t_reset();
    t_active();
    t_periph();
    t_standby();
    t_sleep();
    results();
  end
  // whole run needs about 400 cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    results();
  end
endmodule
